// ==== rvm_params.svh ====
/*
 * rvm_params.svh: register offsets, field positions, reset values and
 * codes of the regulator voltage monitor.
 * assumes: included by its bare name from design files.
 */
`ifndef RVM_PARAMS_SVH
`define RVM_PARAMS_SVH

// register offsets (9-bit register space)
`define RVM_OFS_CONFIG      9'h114
`define RVM_OFS_EN_LIN_A    9'h115
`define RVM_OFS_EN_LIN_B    9'h116
`define RVM_OFS_EN_SW       9'h117
`define RVM_OFS_IDX_CH8_CH9 9'h11e
`define RVM_OFS_IDX_CH10    9'h11f

// reset values
`define RVM_RST_CONFIG      8'h00
`define RVM_RST_EN_LIN_A    8'h00
`define RVM_RST_EN_LIN_B    8'h00
`define RVM_RST_EN_SW       8'h00
`define RVM_RST_IDX         3'h0

// writable bits of the enable registers
`define RVM_MASK_EN_LIN_A   8'hc4
`define RVM_MASK_EN_LIN_B   8'h05
`define RVM_MASK_EN_SW      8'hfc

// config fields
`define RVM_DELAY_HI        7
`define RVM_DELAY_LO        6
`define RVM_OPER_HI         5
`define RVM_OPER_LO         4
`define RVM_DEB_BIT         3
`define RVM_RESET_EN_BIT    2
`define RVM_THRES_HI        1
`define RVM_THRES_LO        0

// enable bit positions
`define RVM_BIT_LIN_8       7
`define RVM_BIT_LIN_7       6
`define RVM_BIT_LIN_3       2
`define RVM_BIT_LIN_11      2
`define RVM_BIT_LIN_9       0
`define RVM_BIT_SW_CORE1    2

// measurements to skip after enable, per delay code
`define RVM_SKIP_0          3'h0
`define RVM_SKIP_1          3'h1
`define RVM_SKIP_2          3'h2
`define RVM_SKIP_3          3'h4

// threshold: limit = target >> (base + code)
`define RVM_THRES_SHIFT     3'h2

// converter channel codes
`define RVM_CH8             2'h0
`define RVM_CH9             2'h1
`define RVM_CH10            2'h2

// index codes
`define RVM_IDX_NONE        3'h0
`define RVM_IDX8_CORE1      3'h1
`define RVM_IDX8_CORE2      3'h2
`define RVM_IDX8_PRO        3'h3
`define RVM_IDX8_LIN3       3'h4
`define RVM_IDX8_LIN11      3'h6
`define RVM_IDX9_IO         3'h1
`define RVM_IDX9_MEM        3'h2
`define RVM_IDX9_PERI       3'h3
`define RVM_IDX10_LIN7      3'h2
`define RVM_IDX10_LIN8      3'h3
`define RVM_IDX10_LIN9      3'h4

// rail numbering
`define RVM_RAIL_CORE1      4'h0
`define RVM_RAIL_CORE2      4'h1
`define RVM_RAIL_PRO        4'h2
`define RVM_RAIL_IO         4'h3
`define RVM_RAIL_MEM        4'h4
`define RVM_RAIL_PERI       4'h5
`define RVM_RAIL_LIN3       4'h6
`define RVM_RAIL_LIN7       4'h7
`define RVM_RAIL_LIN8       4'h8
`define RVM_RAIL_LIN9       4'h9
`define RVM_RAIL_LIN11      4'ha
`define RVM_RAIL_NONE       4'hf
`define RVM_NUM_RAILS       11

`endif

// ==== rvm_pkg.sv ====
/*
 * rvm_pkg.sv: types of the regulator voltage monitor.
 * assumes: rvm_params.svh sits in the same folder.
 */
package rvm_pkg;
    typedef enum logic [1:0] {
        RVM_OPER_LOCKOUT = 2'b00,
        RVM_OPER_NORMAL  = 2'b01,
        RVM_OPER_BURST   = 2'b10,
        RVM_OPER_RSVD    = 2'b11
    } rvm_oper_t;

    typedef logic [3:0] rvm_rail_t;
endpackage

// ==== rvm_range_check.sv ====
/*
 * rvm_range_check.sv: combinational deviation check of one measurement
 * against its target.
 * assumes: value and target share one scale; target above zero.
 */
`timescale 1ns/1ps
`include "rvm_params.svh"

module rvm_range_check
    import rvm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // measurement
    input  wire logic [WIDTH-1:0] value,
    input  wire logic [WIDTH-1:0] target,
    input  wire logic [1:0]       thres,
    // result
    output logic                  out_of_range
);
    logic [WIDTH-1:0] diff;
    logic [WIDTH-1:0] limit;
    logic [2:0]       shift;

    always_comb begin
        shift = `RVM_THRES_SHIFT + {1'b0, thres};
        diff  = (value >= target) ? (value - target) : (target - value);
        // 25, 12.5, 6.25, 3.125 percent of target
        limit = target >> shift; // [RULE8]
        out_of_range = diff > limit; // [RULE15]
    end
endmodule // rvm_range_check

// ==== rvm_monitor.sv ====
/*
 * rvm_monitor.sv: configuration, enable and index registers of the
 * regulator voltage monitor, with per-rail start delay, debounce and
 * the event, shutdown and reset decisions.
 * assumes: register port driven by the chip's serial interface logic;
 * measurement results arrive as one-cycle strobes from the converter
 * sequencer; event latching and interrupt masking lie outside.
 */
// What this block does
// (RULE1) A two-bit delay field holds comparison off for 0, 1, 2 or 4 measurements after a rail is enabled.
// (RULE2) In lockout operation an out-of-range rail raises the event and interrupt and shuts that rail down; code 11 is reserved.
// (RULE3) In normal auto operation every finished measurement on channels 8, 9 or 10 raises the event and interrupt.
// (RULE4) In burst operation the event and interrupt come once, after the channel 10 slot is processed.
// (RULE5) Bit 3 switches debouncing of monitor results off (0) or on (1).
// (RULE6) With bit 2 set and the event mask bit at 1 an out-of-range result pulls the system reset low.
// (RULE7) Software should set the reset enable only at run time, not in the factory defaults.
// (RULE8) The two-bit threshold picks a deviation of about 25, 12.5, 6.25 or 3.125 percent.
// (RULE9) The first linear enable register watches linear rails 8, 7 and 3 on bits 7, 6 and 2.
// (RULE10) The second linear enable register watches linear rails 11 and 9 on bits 2 and 0.
// (RULE11) The switcher enable register watches six switchers on bits 7 down to 2.
// (RULE12) A read-only field in bits 6:4 names the rail of the latest channel 9 measurement.
// (RULE13) A read-only field in bits 2:0 names the rail of the latest channel 8 measurement.
// (RULE14) A separate read-only register names the rail of the latest channel 10 measurement.
// (RULE15) A watched rail is out of range when it deviates from target beyond the threshold.
// (RULE16) Each index field updates when a measurement completes on its channel.
`timescale 1ns/1ps
`include "rvm_params.svh"

module rvm_monitor
    import rvm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // register port
    input  wire logic [8:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    // measurement strobe from the sequencer
    input  wire logic             meas_valid,
    input  wire logic [1:0]       meas_channel,
    input  wire logic [2:0]       meas_index,
    input  wire logic [WIDTH-1:0] meas_value,
    input  wire logic [WIDTH-1:0] meas_target,
    // regulator state and event mask
    input  wire logic [10:0]      rail_on,
    input  wire logic             rail_range_event_mask,
    // results
    output logic                  rail_range_event,
    output logic                  interrupt_request_n,
    output logic      [10:0]      rail_shutdown,
    output logic                  system_reset_out_n
);
    localparam int NR = `RVM_NUM_RAILS;

    logic [7:0]  monitor_config;
    logic [7:0]  monitor_enable_linear_a;
    logic [7:0]  monitor_enable_linear_b;
    logic [7:0]  monitor_enable_switchers;
    logic [2:0]  ch8_last_rail;
    logic [2:0]  ch9_last_rail;
    logic [2:0]  ch10_last_rail;
    logic [7:0]  next_monitor_config;
    logic [7:0]  next_monitor_enable_linear_a;
    logic [7:0]  next_monitor_enable_linear_b;
    logic [7:0]  next_monitor_enable_switchers;
    logic [2:0]  next_ch8_last_rail;
    logic [2:0]  next_ch9_last_rail;
    logic [2:0]  next_ch10_last_rail;
    logic [7:0]  next_reg_rdata;

    logic                  next_rail_range_event;
    logic [10:0]           next_rail_shutdown;
    logic                  next_reset_n;

    rvm_oper_t   oper;
    logic [2:0]  skip_need;
    logic        debounce_on;
    logic [10:0] watch;
    rvm_rail_t   meas_rail;
    logic        raw_oor;
    // one bit per rail, each driven from its own generate slice
    wire  [10:0] fault;

    // map channel and index code onto the rail number
    function automatic rvm_rail_t rail_of(input logic [1:0] ch,
                                          input logic [2:0] idx);
        rvm_rail_t r;
        r = `RVM_RAIL_NONE;
        case (ch)
            `RVM_CH8: begin
                case (idx)
                    `RVM_IDX8_CORE1: r = `RVM_RAIL_CORE1;
                    `RVM_IDX8_CORE2: r = `RVM_RAIL_CORE2;
                    `RVM_IDX8_PRO:   r = `RVM_RAIL_PRO;
                    `RVM_IDX8_LIN3:  r = `RVM_RAIL_LIN3;
                    `RVM_IDX8_LIN11: r = `RVM_RAIL_LIN11;
                    default:         r = `RVM_RAIL_NONE;
                endcase
            end
            `RVM_CH9: begin
                case (idx)
                    `RVM_IDX9_IO:   r = `RVM_RAIL_IO;
                    `RVM_IDX9_MEM:  r = `RVM_RAIL_MEM;
                    `RVM_IDX9_PERI: r = `RVM_RAIL_PERI;
                    default:        r = `RVM_RAIL_NONE;
                endcase
            end
            `RVM_CH10: begin
                case (idx)
                    `RVM_IDX10_LIN7: r = `RVM_RAIL_LIN7;
                    `RVM_IDX10_LIN8: r = `RVM_RAIL_LIN8;
                    `RVM_IDX10_LIN9: r = `RVM_RAIL_LIN9;
                    default:         r = `RVM_RAIL_NONE;
                endcase
            end
            default: r = `RVM_RAIL_NONE;
        endcase
        return r;
    endfunction

    // configuration decode
    always_comb begin
        oper = rvm_oper_t'(monitor_config[`RVM_OPER_HI:`RVM_OPER_LO]);
        debounce_on = monitor_config[`RVM_DEB_BIT]; // [RULE5]
        case (monitor_config[`RVM_DELAY_HI:`RVM_DELAY_LO]) // [RULE1]
            2'b00:   skip_need = `RVM_SKIP_0;
            2'b01:   skip_need = `RVM_SKIP_1;
            2'b10:   skip_need = `RVM_SKIP_2;
            2'b11:   skip_need = `RVM_SKIP_3;
            default: skip_need = `RVM_SKIP_0;
        endcase
        watch = '0;
        watch[5:0] = monitor_enable_switchers[7:2]; // [RULE11]
        watch[`RVM_RAIL_LIN3] =
            monitor_enable_linear_a[`RVM_BIT_LIN_3]; // [RULE9]
        watch[`RVM_RAIL_LIN7] =
            monitor_enable_linear_a[`RVM_BIT_LIN_7]; // [RULE9]
        watch[`RVM_RAIL_LIN8] =
            monitor_enable_linear_a[`RVM_BIT_LIN_8]; // [RULE9]
        watch[`RVM_RAIL_LIN9] =
            monitor_enable_linear_b[`RVM_BIT_LIN_9]; // [RULE10]
        watch[`RVM_RAIL_LIN11] =
            monitor_enable_linear_b[`RVM_BIT_LIN_11]; // [RULE10]
        meas_rail = rail_of(meas_channel, meas_index);
    end

    rvm_range_check #(
        .WIDTH        (WIDTH)
    ) u_check (
        .value        (meas_value),
        .target       (meas_target),
        .thres        (monitor_config[`RVM_THRES_HI:`RVM_THRES_LO]),
        .out_of_range (raw_oor)
    );

    // per-rail start delay and debounce
    genvar g;
    generate
        for (g = 0; g < NR; g++) begin : g_rail
            logic [2:0] seen;
            logic       strike;
            logic [2:0] next_seen;
            logic       next_strike;
            logic       armed;
            logic       hit_here;
            logic       fault_here;

            assign fault[g] = fault_here;

            always_comb begin
                armed = seen >= skip_need; // [RULE1]
                hit_here = meas_valid && (meas_rail == rvm_rail_t'(g));
                next_seen = seen;
                next_strike = strike;
                fault_here = 1'b0;
                if (!rail_on[g]) begin
                    next_seen = '0;
                    next_strike = 1'b0;
                end else if (hit_here) begin
                    if (!armed) begin
                        next_seen = seen + 3'h1; // [RULE1]
                    end else if (watch[g] && raw_oor) begin
                        // two results in a row when debouncing
                        fault_here = !debounce_on || strike; // [RULE5]
                        next_strike = 1'b1;
                    end else begin
                        next_strike = 1'b0;
                    end
                end
            end

            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    seen <= 3'h0;
                    strike <= 1'b0;
                end else begin
                    seen <= next_seen;
                    strike <= next_strike;
                end
            end
        end
    endgenerate

    // event, shutdown and reset decisions
    always_comb begin
        next_rail_range_event = 1'b0;
        next_rail_shutdown = '0;
        case (oper)
            RVM_OPER_LOCKOUT: begin
                next_rail_range_event = |fault; // [RULE2]
                next_rail_shutdown = fault; // [RULE2]
            end
            RVM_OPER_NORMAL: begin
                next_rail_range_event = meas_valid &&
                    (meas_channel != 2'h3); // [RULE3]
            end
            RVM_OPER_BURST: begin
                next_rail_range_event = meas_valid &&
                    (meas_channel == `RVM_CH10); // [RULE4]
            end
            default: next_rail_range_event = 1'b0;
        endcase
        next_reset_n = !(monitor_config[`RVM_RESET_EN_BIT] &&
            rail_range_event_mask && (|fault)); // [RULE6]
    end

    // register writes and index capture
    always_comb begin
        next_monitor_config = monitor_config;
        next_monitor_enable_linear_a = monitor_enable_linear_a;
        next_monitor_enable_linear_b = monitor_enable_linear_b;
        next_monitor_enable_switchers = monitor_enable_switchers;
        if (reg_wr) begin
            case (reg_addr)
                `RVM_OFS_CONFIG: next_monitor_config = reg_wdata;
                `RVM_OFS_EN_LIN_A: next_monitor_enable_linear_a =
                    reg_wdata & `RVM_MASK_EN_LIN_A; // [RULE9]
                `RVM_OFS_EN_LIN_B: next_monitor_enable_linear_b =
                    reg_wdata & `RVM_MASK_EN_LIN_B; // [RULE10]
                `RVM_OFS_EN_SW: next_monitor_enable_switchers =
                    reg_wdata & `RVM_MASK_EN_SW; // [RULE11]
                default: ;
            endcase
        end
        next_ch8_last_rail = ch8_last_rail;
        next_ch9_last_rail = ch9_last_rail;
        next_ch10_last_rail = ch10_last_rail;
        if (meas_valid) begin
            case (meas_channel) // [RULE16]
                `RVM_CH8:  next_ch8_last_rail = meas_index; // [RULE13]
                `RVM_CH9:  next_ch9_last_rail = meas_index; // [RULE12]
                `RVM_CH10: next_ch10_last_rail = meas_index; // [RULE14]
                default: ;
            endcase
        end
        next_reg_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `RVM_OFS_CONFIG:   next_reg_rdata = monitor_config;
                `RVM_OFS_EN_LIN_A: next_reg_rdata = monitor_enable_linear_a;
                `RVM_OFS_EN_LIN_B: next_reg_rdata = monitor_enable_linear_b;
                `RVM_OFS_EN_SW:    next_reg_rdata = monitor_enable_switchers;
                `RVM_OFS_IDX_CH8_CH9: next_reg_rdata =
                    {1'b0, ch9_last_rail, 1'b0, ch8_last_rail}; // [RULE12]
                `RVM_OFS_IDX_CH10: next_reg_rdata =
                    {5'h00, ch10_last_rail}; // [RULE14]
                default: next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            monitor_config <= `RVM_RST_CONFIG;
            monitor_enable_linear_a <= `RVM_RST_EN_LIN_A;
            monitor_enable_linear_b <= `RVM_RST_EN_LIN_B;
            monitor_enable_switchers <= `RVM_RST_EN_SW;
            ch8_last_rail <= `RVM_RST_IDX;
            ch9_last_rail <= `RVM_RST_IDX;
            ch10_last_rail <= `RVM_RST_IDX;
            reg_rdata <= 8'h00;
            rail_range_event <= 1'b0;
            interrupt_request_n <= 1'b1;
            rail_shutdown <= 11'h000;
            system_reset_out_n <= 1'b1;
        end else begin
            monitor_config <= next_monitor_config;
            monitor_enable_linear_a <= next_monitor_enable_linear_a;
            monitor_enable_linear_b <= next_monitor_enable_linear_b;
            monitor_enable_switchers <= next_monitor_enable_switchers;
            ch8_last_rail <= next_ch8_last_rail;
            ch9_last_rail <= next_ch9_last_rail;
            ch10_last_rail <= next_ch10_last_rail;
            reg_rdata <= next_reg_rdata;
            rail_range_event <= next_rail_range_event;
            interrupt_request_n <= !next_rail_range_event; // [RULE2]
            rail_shutdown <= next_rail_shutdown;
            system_reset_out_n <= next_reset_n; // [RULE6]
        end
    end
endmodule // rvm_monitor

// ==== rvm_monitor_chk.sv ====
/*
 * rvm_monitor_chk.sv: port-level assertions of the rail monitor.
 * assumes: bound to rvm_monitor; config shadowed from register writes.
 */
`timescale 1ns/1ps
`include "rvm_params.svh"

module rvm_monitor_chk
    import rvm_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [8:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic [7:0]  reg_rdata,
    // measurement and mask
    input  wire logic        meas_valid,
    input  wire logic [1:0]  meas_channel,
    input  wire logic        rail_range_event_mask,
    // results
    input  wire logic        rail_range_event,
    input  wire logic        interrupt_request_n,
    input  wire logic [10:0] rail_shutdown,
    input  wire logic        system_reset_out_n
);
    logic [7:0] cfg;
    logic [7:0] next_cfg;

    always_comb begin
        next_cfg = cfg;
        if (reg_wr && reg_addr == `RVM_OFS_CONFIG) begin
            next_cfg = reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfg <= 8'h00;
        end else begin
            cfg <= next_cfg;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_read_idle:
        assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_irq_with_event:
        assert property (interrupt_request_n == !rail_range_event)
        else $error("interrupt and event differ");
    a_event_cause:
        assert property (rail_range_event |-> $past(meas_valid))
        else $error("event without measurement");
    a_normal_event:
        assert property (meas_valid && meas_channel != 2'h3
            && cfg[5:4] == RVM_OPER_NORMAL |=> rail_range_event)
        else $error("normal mode event missing");
    a_burst_once:
        assert property (meas_valid && cfg[5:4] == RVM_OPER_BURST
            |=> rail_range_event == $past(meas_channel == `RVM_CH10))
        else $error("burst event wrong");
    a_reserved_quiet:
        assert property (cfg[5:4] == RVM_OPER_RSVD |=> !rail_range_event)
        else $error("event in reserved mode");
    a_shutdown_lockout:
        assert property (|rail_shutdown |-> rail_range_event
            && $past(cfg[5:4]) == RVM_OPER_LOCKOUT)
        else $error("shutdown outside lockout");
    a_reset_gate:
        assert property (!system_reset_out_n
            |-> $past(meas_valid && cfg[2] && rail_range_event_mask))
        else $error("reset out not enabled");
    a_shutdown_single:
        assert property ($onehot0(rail_shutdown))
        else $error("several rails shut down");

    c_normal: cover property (rail_range_event && cfg[5:4] == 2'h1);
    c_shutdown: cover property (|rail_shutdown);
    c_reset: cover property (!system_reset_out_n);
endmodule // rvm_monitor_chk

bind rvm_monitor rvm_monitor_chk rvm_monitor_chk_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .meas_valid(meas_valid),
    .meas_channel(meas_channel),
    .rail_range_event_mask(rail_range_event_mask),
    .rail_range_event(rail_range_event),
    .interrupt_request_n(interrupt_request_n),
    .rail_shutdown(rail_shutdown),
    .system_reset_out_n(system_reset_out_n));

// ==== rvm_rail_model.sv ====
/*
 * rvm_rail_model.sv: converter sequencer and regulator states.
 * assumes: tasks called from the bench; drives at falling edges.
 */
`timescale 1ns/1ps

module rvm_rail_model (
    // clock
    input  wire logic        core_clk,
    // measurement strobe
    output logic             meas_valid,
    output logic [1:0]       meas_channel,
    output logic [2:0]       meas_index,
    output logic [7:0]       meas_value,
    output logic [7:0]       meas_target,
    // regulator state
    output logic [10:0]      rail_on
);
    initial begin
        meas_valid = 1'b0;
        meas_channel = 2'h3;
        meas_index = 3'h7;
        meas_value = 8'h00;
        meas_target = 8'h00;
        rail_on = 11'h000;
    end

    task automatic send(input logic [1:0] ch, input logic [2:0] idx,
                        input logic [7:0] val, input logic [7:0] tgt);
        @(negedge core_clk);
        meas_valid = 1'b1;
        meas_channel = ch;
        meas_index = idx;
        meas_value = val;
        meas_target = tgt;
        @(negedge core_clk);
        meas_valid = 1'b0;
        // stale result scrambled once the strobe is gone
        meas_channel = ~ch;
        meas_index = ~idx;
        meas_value = ~val;
        meas_target = ~tgt;
    endtask

    task automatic set_rails(input logic [10:0] v);
        @(negedge core_clk);
        rail_on = v;
    endtask
endmodule // rvm_rail_model

// ==== rvm_monitor_test.sv ====
/*
 * rvm_monitor_test.sv: self-checking bench of the rail monitor.
 * assumes: model drives measurements; core1 rail target 0x64.
 */
`timescale 1ns/1ps
`include "rvm_params.svh"

module rvm_monitor_test;
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } rvm_row_t;

    localparam logic [13:0] out_idle = 14'h1800;
    localparam logic [13:0] out_ev   = 14'h2800;
    localparam logic [13:0] out_sd   = 14'h2801;
    localparam logic [13:0] out_rs   = 14'h2001;

    logic        core_clk;
    logic        sys_rst;
    logic [8:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        meas_valid;
    logic [1:0]  meas_channel;
    logic [2:0]  meas_index;
    logic [7:0]  meas_value;
    logic [7:0]  meas_target;
    logic [10:0] rail_on;
    logic        rail_range_event_mask;
    logic        rail_range_event;
    logic        interrupt_request_n;
    logic [10:0] rail_shutdown;
    logic        system_reset_out_n;
    int          fail_count;
    int          check_count;
    rvm_row_t    rows [7];

    rvm_monitor #(.WIDTH(8)) rvm_monitor_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .meas_valid(meas_valid),
        .meas_channel(meas_channel), .meas_index(meas_index),
        .meas_value(meas_value), .meas_target(meas_target),
        .rail_on(rail_on),
        .rail_range_event_mask(rail_range_event_mask),
        .rail_range_event(rail_range_event),
        .interrupt_request_n(interrupt_request_n),
        .rail_shutdown(rail_shutdown),
        .system_reset_out_n(system_reset_out_n));

    rvm_rail_model rvm_rail_model_i (
        .core_clk(core_clk), .meas_valid(meas_valid),
        .meas_channel(meas_channel), .meas_index(meas_index),
        .meas_value(meas_value), .meas_target(meas_target),
        .rail_on(rail_on));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [8:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask

    task automatic chk_reg(input logic [8:0] a, input logic [7:0] e);
        logic [7:0] g;
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        g = reg_rdata;
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED reg %h expected %h seen %h", a, e, g);
        end
    endtask

    task automatic meas(input logic [1:0] ch, input logic [2:0] idx,
                        input logic [7:0] v, input logic [13:0] e);
        logic [13:0] g;
        rvm_rail_model_i.send(ch, idx, v, 8'h64);
        g = {rail_range_event, interrupt_request_n, system_reset_out_n,
             rail_shutdown};
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED outputs expected %h seen %h", e, g);
        end
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        complete_run();
    end

    initial begin
        fail_count = 0;
        check_count = 0;
        sys_rst = 1'b1;
        reg_addr = 9'h000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        rail_range_event_mask = 1'b0;
        rows = '{{9'h114, 8'hff, 8'hff}, {9'h115, 8'hff, 8'hc4},
                 {9'h116, 8'hff, 8'h05}, {9'h117, 8'hff, 8'hfc},
                 {9'h11e, 8'hff, 8'h00}, {9'h11f, 8'hff, 8'h00},
                 {9'h113, 8'hff, 8'h00}};
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            chk_reg(rows[i].addr, 8'h00);
        end
        foreach (rows[i]) begin
            reg_write(rows[i].addr, rows[i].wdata);
            chk_reg(rows[i].addr, rows[i].rdata);
        end
        rvm_rail_model_i.set_rails(11'h001);
        reg_write(`RVM_OFS_CONFIG, 8'h00);
        meas(2'h0, 3'h1, 8'h7d, out_idle);
        meas(2'h0, 3'h1, 8'h82, out_sd);
        chk_reg(`RVM_OFS_IDX_CH8_CH9, 8'h01);
        reg_write(`RVM_OFS_CONFIG, 8'h03);
        meas(2'h0, 3'h1, 8'h67, out_idle);
        meas(2'h0, 3'h1, 8'h68, out_sd);
        reg_write(`RVM_OFS_EN_SW, 8'h00);
        meas(2'h0, 3'h1, 8'h82, out_idle);
        reg_write(`RVM_OFS_EN_SW, 8'hfc);
        rail_range_event_mask = 1'b1;
        reg_write(`RVM_OFS_CONFIG, 8'h04);
        meas(2'h0, 3'h1, 8'h82, out_rs);
        rail_range_event_mask = 1'b0;
        meas(2'h0, 3'h1, 8'h82, out_sd);
        reg_write(`RVM_OFS_CONFIG, 8'hc0);
        rvm_rail_model_i.set_rails(11'h000);
        rvm_rail_model_i.set_rails(11'h001);
        repeat (4) meas(2'h0, 3'h1, 8'h82, out_idle);
        meas(2'h0, 3'h1, 8'h82, out_sd);
        reg_write(`RVM_OFS_CONFIG, 8'h08);
        meas(2'h0, 3'h1, 8'h64, out_idle);
        meas(2'h0, 3'h1, 8'h82, out_idle);
        meas(2'h0, 3'h1, 8'h82, out_sd);
        reg_write(`RVM_OFS_CONFIG, 8'h10);
        meas(2'h1, 3'h3, 8'h64, out_ev);
        chk_reg(`RVM_OFS_IDX_CH8_CH9, 8'h31);
        reg_write(`RVM_OFS_CONFIG, 8'h20);
        meas(2'h0, 3'h2, 8'h64, out_idle);
        meas(2'h2, 3'h2, 8'h64, out_ev);
        chk_reg(`RVM_OFS_IDX_CH10, 8'h02);
        reg_write(`RVM_OFS_CONFIG, 8'h00);
        rvm_rail_model_i.set_rails(11'h501);
        meas(2'h0, 3'h6, 8'h82, 14'h2c00);
        meas(2'h2, 3'h3, 8'h82, 14'h2900);
        reg_write(`RVM_OFS_CONFIG, 8'h30);
        meas(2'h0, 3'h1, 8'h82, out_idle);
        // reset again in mid-run: registers and indices back to zero
        @(negedge core_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        chk_reg(`RVM_OFS_CONFIG, 8'h00);
        chk_reg(`RVM_OFS_IDX_CH10, 8'h00);
        complete_run();
    end
endmodule // rvm_monitor_test
